// ===== rtl/ucs_pkg.sv
package ucs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_FRAME_CTL  = 10'h0e2;
  localparam logic [9:0]  IDX_ENABLE_CTL = 10'h0e3;
  localparam logic [9:0]  IDX_ROLE_CTL   = 10'h0e4;
  localparam logic [9:0]  IDX_STATUS     = 10'h0e5;
  localparam logic [9:0]  IDX_BUFFER     = 10'h0e7;
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] ADDR_FRAME_CTL  = {IDX_FRAME_CTL, 2'b00};
  localparam logic [11:0] ADDR_ENABLE_CTL = {IDX_ENABLE_CTL, 2'b00};
  localparam logic [11:0] ADDR_ROLE_CTL   = {IDX_ROLE_CTL, 2'b00};
  localparam logic [11:0] ADDR_STATUS     = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_BUFFER     = {IDX_BUFFER, 2'b00};
  // Reset values
  localparam logic [7:0]  RST_CTL    = 8'h00;
  localparam logic [7:0]  RST_STATUS = 8'h80;
  // Frame control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PAR_HI  = 5;
  localparam int PAR_LO  = 4;
  localparam int SIZE_HI = 3;
  localparam int SIZE_LO = 1;
  localparam int ORDER_B = 2;
  localparam int PHASE_B = 1;
  localparam int POL_B   = 0;
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_SPI   = 2'h3;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [1:0] PAR_ODD    = 2'h3;
  localparam logic [2:0] SIZE_9     = 3'h7;
  localparam logic [3:0] BITS_5     = 4'h5;
  localparam logic [3:0] BITS_8     = 4'h8;
  localparam logic [3:0] BITS_9     = 4'h9;
  localparam logic [3:0] BITS_NONE  = 4'h0;
  // Enable control and role control bits
  localparam int EN_MODULE = 1;
  localparam int EN_DOUBLE = 0;
  localparam int EN_TX     = 3;
  localparam int EN_RX     = 2;
  localparam int ROLE_MASTER = 7;
  localparam int ROLE_LOOP   = 6;
  localparam int ROLE_GATE   = 5;
  localparam int ROLE_SSOUT  = 4;
  localparam int ROLE_STOP2  = 2;
  localparam int ROLE_TX9    = 1;
  localparam logic [7:0] ROLE_WMASK = 8'hf6;
  // Status bits
  localparam int ST_BEMPTY = 7;
  localparam int ST_TXC    = 6;
  localparam int ST_WAKE   = 4;
  localparam int ST_SRST   = 3;
  localparam int IRQ_HI    = 7;
  localparam int IRQ_LO    = 4;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ucs_pkg

// ===== rtl/ucs_usart_ctrl.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ucs_usart_ctrl (
  // Clock, reset and clock enable
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        ce,
  // AXI4-Lite slave
  input  wire  logic [11:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [11:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Shift engine, transmit side
  output logic [8:0]        tx_data,
  output logic              tx_valid,
  input  wire  logic        tx_ready,
  input  wire  logic        tx_frame_done,
  input  wire  logic        frame_active,
  input  wire  logic        baud_tick,
  // Shift engine, receive side
  input  wire  logic        rx_valid,
  input  wire  logic [8:0]  rx_data,
  input  wire  logic        rx_stop_bad,
  input  wire  logic        rx_parity_bad,
  // System
  input  wire  logic        stop_mode,
  input  wire  logic        txc_irq_ack,
  output logic              irq,
  // Decoded configuration
  output logic              mode_async,
  output logic              mode_sync,
  output logic              mode_spi,
  output logic              parity_en,
  output logic              parity_odd,
  output logic [3:0]        data_bits,
  output logic              msb_first,
  output logic              two_stop,
  output logic              sample_rising,
  output logic              double_speed,
  output logic              tx_enable,
  output logic              rx_enable,
  output logic              port_clock_run,
  output logic              loopback_en,
  output logic              edge_sample,
  output logic              edge_setup,
  output logic              slave_selected,
  // Pins
  input  wire  logic        rx_pin,
  input  wire  logic        sclk_in,
  output logic              sclk_out,
  output logic              sclk_oe,
  input  wire  logic        ss_n_in,
  output logic              ss_n_out,
  output logic              ss_oe
);

  logic [7:0]  frame_ctl_ff;
  logic [7:0]  enable_ctl_ff;
  logic [7:0]  role_ctl_ff;
  logic        bempty_ff;
  logic        txc_ff;
  logic        rx_full_ff;
  logic        wake_ff;
  logic        soft_rst_ff;
  logic        dor_ff;
  logic        fe_ff;
  logic        pe_ff;
  logic [8:0]  tx_buf_ff;
  logic        tx_full_ff;
  logic [8:0]  rx_buf_ff;
  logic        irq_ff;
  logic [7:0]  status;
  logic        int_rst;

  // Write and read channel holding registers
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [11:0] aw_addr_ff;
  logic [7:0]  w_data_ff;
  logic        w_lane_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        wr_do;
  logic        wr_en;
  logic        ar_hs;
  logic        rd_buf;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [7:0]  rd_value;

  assign int_rst = !aresetn || soft_rst_ff;
  assign status  = {bempty_ff, txc_ff, rx_full_ff, wake_ff, soft_rst_ff, dor_ff, fe_ff, pe_ff};

  // Configuration decode
  assign mode_async     = frame_ctl_ff[ucs_pkg::MODE_HI:ucs_pkg::MODE_LO] == ucs_pkg::MODE_ASYNC;
  assign mode_sync      = frame_ctl_ff[ucs_pkg::MODE_HI:ucs_pkg::MODE_LO] == ucs_pkg::MODE_SYNC;
  assign mode_spi       = frame_ctl_ff[ucs_pkg::MODE_HI:ucs_pkg::MODE_LO] == ucs_pkg::MODE_SPI;
  assign parity_en      = !mode_spi
                       && (frame_ctl_ff[ucs_pkg::PAR_HI:ucs_pkg::PAR_LO] == ucs_pkg::PAR_EVEN
                       ||  frame_ctl_ff[ucs_pkg::PAR_HI:ucs_pkg::PAR_LO] == ucs_pkg::PAR_ODD);
  assign parity_odd     = parity_en
                       && frame_ctl_ff[ucs_pkg::PAR_HI:ucs_pkg::PAR_LO] == ucs_pkg::PAR_ODD;
  assign msb_first      = mode_spi && frame_ctl_ff[ucs_pkg::ORDER_B];
  assign two_stop       = !mode_spi && role_ctl_ff[ucs_pkg::ROLE_STOP2];
  // Sample edge: polarity alone outside SPI, polarity with phase in SPI
  assign sample_rising  = mode_spi ? (frame_ctl_ff[ucs_pkg::POL_B] == frame_ctl_ff[ucs_pkg::PHASE_B])
                                   : frame_ctl_ff[ucs_pkg::POL_B];
  assign double_speed   = mode_async && enable_ctl_ff[ucs_pkg::EN_DOUBLE];
  assign tx_enable      = enable_ctl_ff[ucs_pkg::EN_TX];
  assign rx_enable      = enable_ctl_ff[ucs_pkg::EN_RX];
  assign port_clock_run = ce && enable_ctl_ff[ucs_pkg::EN_MODULE];
  assign loopback_en    = role_ctl_ff[ucs_pkg::ROLE_LOOP];
  assign irq            = irq_ff;

  always_comb begin
    unique case (frame_ctl_ff[ucs_pkg::SIZE_HI:ucs_pkg::SIZE_LO])
      3'h0, 3'h1, 3'h2, 3'h3: data_bits = ucs_pkg::BITS_5
                                 + {1'b0, frame_ctl_ff[ucs_pkg::SIZE_HI:ucs_pkg::SIZE_LO]};
      ucs_pkg::SIZE_9:       data_bits = ucs_pkg::BITS_9;
      default:               data_bits = ucs_pkg::BITS_NONE;
    endcase
    if (mode_spi) begin
      data_bits = ucs_pkg::BITS_8;
    end
  end

  // AXI4-Lite: address and data taken in either order, answered after both
  assign s_axi_awready = ce && !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = ce && !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = ce && !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign wr_do         = ce && aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_mapped     = aw_addr_ff inside {ucs_pkg::ADDR_FRAME_CTL, ucs_pkg::ADDR_ENABLE_CTL,
                                            ucs_pkg::ADDR_ROLE_CTL, ucs_pkg::ADDR_STATUS,
                                            ucs_pkg::ADDR_BUFFER};
  assign wr_en         = wr_do && w_lane_ff;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign rd_mapped     = s_axi_araddr inside {ucs_pkg::ADDR_FRAME_CTL, ucs_pkg::ADDR_ENABLE_CTL,
                                              ucs_pkg::ADDR_ROLE_CTL, ucs_pkg::ADDR_STATUS,
                                              ucs_pkg::ADDR_BUFFER};
  assign rd_buf        = ar_hs && s_axi_araddr == ucs_pkg::ADDR_BUFFER;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_lane_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= ucs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_mapped ? ucs_pkg::RESP_OKAY : ucs_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (s_axi_araddr)
      ucs_pkg::ADDR_FRAME_CTL:  rd_value = frame_ctl_ff;
      ucs_pkg::ADDR_ENABLE_CTL: rd_value = enable_ctl_ff;
      ucs_pkg::ADDR_ROLE_CTL:   rd_value = {role_ctl_ff[7:1], rx_buf_ff[8]};
      ucs_pkg::ADDR_STATUS:     rd_value = status;
      ucs_pkg::ADDR_BUFFER:     rd_value = rx_buf_ff[7:0];
      default:                  rd_value = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= ucs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h000000, rd_value};
        rresp_ff  <= rd_mapped ? ucs_pkg::RESP_OKAY : ucs_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Control registers; untouched by soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_ctl_ff  <= ucs_pkg::RST_CTL;
      enable_ctl_ff <= ucs_pkg::RST_CTL;
      role_ctl_ff   <= ucs_pkg::RST_CTL;
    end else if (wr_en) begin
      if (aw_addr_ff == ucs_pkg::ADDR_FRAME_CTL) begin
        frame_ctl_ff <= w_data_ff;
      end
      if (aw_addr_ff == ucs_pkg::ADDR_ENABLE_CTL) begin
        enable_ctl_ff <= w_data_ff;
      end
      if (aw_addr_ff == ucs_pkg::ADDR_ROLE_CTL) begin
        role_ctl_ff <= w_data_ff & ucs_pkg::ROLE_WMASK;
      end
    end
  end

  // Soft reset pulse, one cycle wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_ff <= 1'b0;
    end else if (ce) begin
      soft_rst_ff <= wr_en && aw_addr_ff == ucs_pkg::ADDR_STATUS
                     && w_data_ff[ucs_pkg::ST_SRST] && !soft_rst_ff;
    end
  end

  // Transmit buffer and its flags
  logic wr_data;
  logic tx_hs;
  logic st_wr;
  assign wr_data  = wr_en && aw_addr_ff == ucs_pkg::ADDR_BUFFER && !tx_full_ff;
  assign st_wr    = wr_en && aw_addr_ff == ucs_pkg::ADDR_STATUS;
  assign tx_valid = tx_full_ff && (tx_enable || role_ctl_ff[ucs_pkg::ROLE_MASTER]);
  assign tx_hs    = tx_valid && tx_ready;
  assign tx_data  = tx_buf_ff;

  always_ff @(posedge aclk) begin
    if (int_rst) begin
      tx_full_ff <= 1'b0;
      tx_buf_ff  <= '0;
      bempty_ff  <= ucs_pkg::RST_STATUS[ucs_pkg::ST_BEMPTY];
      txc_ff     <= 1'b0;
    end else if (ce) begin
      if (wr_data) begin
        tx_full_ff <= 1'b1;
        tx_buf_ff  <= {role_ctl_ff[ucs_pkg::ROLE_TX9], w_data_ff};
      end else if (tx_hs) begin
        tx_full_ff <= 1'b0;
      end
      if (tx_hs) begin
        bempty_ff <= 1'b1;
      end else if (wr_data || (st_wr && !w_data_ff[ucs_pkg::ST_BEMPTY])) begin
        bempty_ff <= 1'b0;
      end
      if (tx_frame_done && !tx_full_ff) begin
        txc_ff <= 1'b1;
      end else if (txc_irq_ack || (st_wr && !w_data_ff[ucs_pkg::ST_TXC])) begin
        txc_ff <= 1'b0;
      end
    end
  end

  // Receive buffer, overrun and error flags
  logic rx_take;
  assign rx_take = rx_valid && rx_enable && !dor_ff;

  always_ff @(posedge aclk) begin
    if (int_rst) begin
      rx_full_ff <= 1'b0;
      rx_buf_ff  <= '0;
      dor_ff     <= 1'b0;
      fe_ff      <= 1'b0;
      pe_ff      <= 1'b0;
    end else if (ce) begin
      if (rx_take && rx_full_ff && !rd_buf) begin
        dor_ff <= 1'b1;
      end else if (rx_take) begin
        rx_full_ff <= 1'b1;
        rx_buf_ff  <= rx_data;
        fe_ff      <= rx_stop_bad;
        pe_ff      <= rx_parity_bad && parity_en;
      end else if (rd_buf) begin
        rx_full_ff <= 1'b0;
        dor_ff     <= 1'b0;
        fe_ff      <= 1'b0;
        pe_ff      <= 1'b0;
      end
    end
  end

  // Pin synchronisers: receive pin, serial clock, slave select
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic       sclk_prev_ff;
  logic       sclk_ff;
  logic       ss_n_ff;
  logic       clk_src;
  logic       run_clk;
  logic       is_master;
  logic       edge_on;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= 3'h7;
      pin_sync_ff <= 3'h7;
    end else if (ce) begin
      pin_meta_ff <= {ss_n_in, sclk_in, rx_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Wake from stop mode
  always_ff @(posedge aclk) begin
    if (int_rst) begin
      wake_ff <= 1'b0;
    end else if (ce) begin
      if (stop_mode && !pin_sync_ff[0] && mode_async) begin
        wake_ff <= 1'b1;
      end else if (st_wr && !w_data_ff[ucs_pkg::ST_WAKE]) begin
        wake_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(status[ucs_pkg::IRQ_HI:ucs_pkg::IRQ_LO]
                & enable_ctl_ff[ucs_pkg::IRQ_HI:ucs_pkg::IRQ_LO]);
    end
  end

  // Serial clock: master drives it, slave samples the pin
  assign is_master = role_ctl_ff[ucs_pkg::ROLE_MASTER] && !mode_async;
  assign run_clk   = is_master && enable_ctl_ff[ucs_pkg::EN_MODULE]
                     && (frame_active || (mode_sync && !role_ctl_ff[ucs_pkg::ROLE_GATE]));
  assign clk_src   = is_master ? sclk_ff : pin_sync_ff[1];
  assign edge_on   = !mode_async && enable_ctl_ff[ucs_pkg::EN_MODULE]
                     && (is_master || !mode_spi || !pin_sync_ff[2]);
  assign sclk_out  = sclk_ff;
  assign sclk_oe   = is_master;
  assign ss_n_out  = ss_n_ff;
  assign ss_oe     = mode_spi && is_master && role_ctl_ff[ucs_pkg::ROLE_SSOUT];
  assign slave_selected = mode_spi && !is_master && !pin_sync_ff[2];

  always_ff @(posedge aclk) begin
    if (int_rst) begin
      sclk_ff      <= 1'b0;
      // Load the slave clock pin, or 0 for a master, so no false edge follows a reset unless a master idles high
      sclk_prev_ff <= is_master ? 1'b0 : pin_sync_ff[1];
      ss_n_ff      <= 1'b1;
      edge_sample  <= 1'b0;
      edge_setup   <= 1'b0;
    end else if (ce) begin
      if (!run_clk) begin
        sclk_ff <= frame_ctl_ff[ucs_pkg::POL_B];
      end else if (baud_tick) begin
        sclk_ff <= !sclk_ff;
      end
      sclk_prev_ff <= clk_src;
      ss_n_ff      <= !frame_active;
      edge_sample  <= edge_on && (clk_src != sclk_prev_ff)
                      && (clk_src == sample_rising);
      edge_setup   <= edge_on && (clk_src != sclk_prev_ff)
                      && (clk_src != sample_rising);
    end
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_overrun;
    ce && rx_take && rx_full_ff && !rd_buf && !soft_rst_ff;
  endsequence

  sequence s_frame_end;
    ce && tx_frame_done && !tx_full_ff && !soft_rst_ff;
  endsequence

  chk_mode_onehot: assert property ($onehot0({mode_async, mode_sync, mode_spi}))
    else $error("mode decode not one-hot");
  chk_parity_odd: assert property (parity_odd |-> parity_en && frame_ctl_ff[ucs_pkg::PAR_LO])
    else $error("odd parity without parity");
  chk_size_nine: assert property (!mode_spi
      && frame_ctl_ff[ucs_pkg::SIZE_HI:ucs_pkg::SIZE_LO] == ucs_pkg::SIZE_9
      |-> data_bits == ucs_pkg::BITS_9)
    else $error("nine-bit length not decoded");
  chk_double_async: assert property (double_speed |-> mode_async)
    else $error("double speed outside async");
  chk_irq_follow: assert property (ce && bempty_ff
      && enable_ctl_ff[ucs_pkg::IRQ_HI] |=> irq)
    else $error("buffer empty interrupt missing");
  chk_txc_set: assert property (s_frame_end |=> txc_ff)
    else $error("transmit complete not set");
  chk_overrun_drop: assert property (s_overrun |=> dor_ff && $stable(rx_buf_ff))
    else $error("overrun not flagged or frame kept");
  chk_soft_clear: assert property (ce && soft_rst_ff |=> !soft_rst_ff && bempty_ff
      && !rx_full_ff)
    else $error("soft reset not self clearing");
  chk_bempty_clear: assert property (ce && wr_data && !soft_rst_ff
      |=> !bempty_ff && tx_full_ff)
    else $error("buffer empty not cleared on load");
  chk_sclk_dir: assert property (sclk_oe |-> role_ctl_ff[ucs_pkg::ROLE_MASTER])
    else $error("serial clock driven as slave");

endmodule : ucs_usart_ctrl

// ===== tb/ucs_shift_model.sv
`timescale 1ns/1ps
module ucs_shift_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Transmit side
  input  wire logic [8:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            tx_frame_done,
  output logic            frame_active,
  output logic            baud_tick,
  // Receive side
  output logic            rx_valid,
  output logic [8:0]      rx_data,
  output logic            rx_stop_bad,
  output logic            rx_parity_bad,
  // Link clock
  output logic            sclk_in
);
  logic [8:0] last_tx;
  logic [4:0] cnt_ff;
  assign tx_ready = !frame_active;
  initial begin
    {rx_valid, rx_data, rx_stop_bad, rx_parity_bad} = '0;
    sclk_in = 1'b1;
    // Link clock runs only inside a frame
    forever begin
      #62.5;
      sclk_in = frame_active ? ~sclk_in : 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    tx_frame_done <= 1'b0;
    if (!aresetn) begin
      frame_active <= 1'b0;
      cnt_ff <= 5'h00;
      baud_tick <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      last_tx <= tx_data;
      frame_active <= 1'b1;
      cnt_ff <= 5'h10;
    end else if (frame_active) begin
      cnt_ff <= cnt_ff - 5'h01;
      baud_tick <= cnt_ff[0];
      if (cnt_ff == 5'h01) begin
        frame_active <= 1'b0;
        tx_frame_done <= 1'b1;
      end
    end
  end
  task automatic push_rx(input logic [8:0] d, input logic fe, input logic pe);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_stop_bad <= fe;
    rx_parity_bad <= pe;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask : push_rx
endmodule : ucs_shift_model

// ===== tb/usart_control_status_regs_tb_top.sv
`timescale 1ns/1ps
module usart_control_status_regs_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack, bv, rv;
  logic awready, wready, arready, irq, txv, txr, fdone, fact, btick, rxv, sbad, pbad, sclk;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [8:0] txd, rxd;
  logic [3:0] dbits;
  logic ma, ms, mspi, pen, podd, msb, transmitter_enable, receiver_enable, pclk, dsp, ce_in, stm, rxp;
  int err_count, total_checks;
  ucs_usart_ctrl uut (.aclk(aclk), .aresetn(aresetn), .ce(ce_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .tx_data(txd),
    .tx_valid(txv), .tx_ready(txr), .tx_frame_done(fdone), .frame_active(fact),
    .baud_tick(btick), .rx_valid(rxv), .rx_data(rxd), .rx_stop_bad(sbad),
    .rx_parity_bad(pbad), .stop_mode(stm), .txc_irq_ack(ack), .irq(irq),
    .mode_async(ma), .mode_sync(ms), .mode_spi(mspi), .parity_en(pen), .parity_odd(podd),
    .data_bits(dbits), .msb_first(msb), .two_stop(), .sample_rising(), .double_speed(dsp),
    .tx_enable(transmitter_enable), .rx_enable(receiver_enable), .port_clock_run(pclk), .loopback_en(),
    .edge_sample(), .edge_setup(), .slave_selected(), .rx_pin(rxp), .sclk_in(sclk),
    .sclk_out(), .sclk_oe(), .ss_n_in(1'b1), .ss_n_out(), .ss_oe());
  ucs_shift_model partner (.aclk(aclk), .aresetn(aresetn), .tx_data(txd), .tx_valid(txv),
    .tx_ready(txr), .tx_frame_done(fdone), .frame_active(fact), .baud_tick(btick),
    .rx_valid(rxv), .rx_data(rxd), .rx_stop_bad(sbad), .rx_parity_bad(pbad),
    .sclk_in(sclk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bv;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rv;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
  endtask : rdr
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rdr(a);
    chk(rd, {24'h000000, e});
  endtask : rchk
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    summarize();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ack, stm} = '0;
    {ce_in, rxp} = 2'h3;
    {awaddr, araddr, wdata} = '0;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(ucs_pkg::ADDR_FRAME_CTL, 8'h00);
    rchk(ucs_pkg::ADDR_ENABLE_CTL, 8'h00);
    rchk(ucs_pkg::ADDR_ROLE_CTL, 8'h00);
    rchk(ucs_pkg::ADDR_STATUS, 8'h80);
    // Modes 00, 01, 11 and reserved 10; parity off in SPI
    for (int i = 0; i < 4; i++) begin
      wr(ucs_pkg::ADDR_FRAME_CTL, {24'h0, i > 1, i == 1 || i == 2, i > 0, i > 1, 4'h6});
      chk({ma, ms, mspi}, {29'h0, i == 0, i == 1, i == 2});
      chk({pen, podd, msb}, {29'h0, i == 1 || i == 3, i == 3, i == 2});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ucs_pkg::ADDR_FRAME_CTL, {24'h0, 4'h0, i[2:0], 1'b0});
      chk(dbits, i < 4 ? 4'h5 + i[3:0] : (i == 7 ? 4'h9 : 4'h0));
    end
    wr(ucs_pkg::ADDR_ENABLE_CTL, 32'h0000000d);
    chk({transmitter_enable, receiver_enable, pclk, dsp}, 4'hd);
    wr(ucs_pkg::ADDR_ENABLE_CTL, 32'h0000008e);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    ce_in <= 1'b0;
    @(posedge aclk);
    chk({awready, wready, arready, pclk}, 4'h0);
    ce_in <= 1'b1;
    @(posedge aclk);
    chk(pclk, 1'b1);
    wr(ucs_pkg::ADDR_STATUS, 32'h00000000);
    rchk(ucs_pkg::ADDR_STATUS, 8'h00);
    chk(irq, 1'b0);
    wr(ucs_pkg::ADDR_ROLE_CTL, 32'h00000002);
    wr(ucs_pkg::ADDR_BUFFER, 32'h000000a5);
    repeat (40) @(posedge aclk);
    chk(partner.last_tx, 9'h1a5);
    rchk(ucs_pkg::ADDR_STATUS, 8'hc0);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    @(posedge aclk);
    rchk(ucs_pkg::ADDR_STATUS, 8'h80);
    partner.push_rx(9'h13c, 1'b1, 1'b0);
    rchk(ucs_pkg::ADDR_STATUS, 8'ha2);
    rchk(ucs_pkg::ADDR_ROLE_CTL, 8'h03);
    partner.push_rx(9'h055, 1'b0, 1'b1);
    rchk(ucs_pkg::ADDR_STATUS, 8'ha6);
    rchk(ucs_pkg::ADDR_BUFFER, 8'h3c);
    rchk(ucs_pkg::ADDR_STATUS, 8'h80);
    partner.push_rx(9'h011, 1'b0, 1'b1);
    wr(ucs_pkg::ADDR_STATUS, 32'h00000088);
    rchk(ucs_pkg::ADDR_STATUS, 8'h80);
    rchk(ucs_pkg::ADDR_FRAME_CTL, 8'h0e);
    // Receive pin low in stop mode, asynchronous frame setting
    stm <= 1'b1;
    rxp <= 1'b0;
    repeat (4) @(posedge aclk);
    rchk(ucs_pkg::ADDR_STATUS, 8'h90);
    stm <= 1'b0;
    rxp <= 1'b1;
    wr(ucs_pkg::ADDR_STATUS, 32'h00000080);
    rchk(ucs_pkg::ADDR_STATUS, 8'h80);
    rdr(12'h000);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, ucs_pkg::RESP_SLVERR});
    wr(12'h000, 32'h00000000);
    chk({30'h0, rs}, {30'h0, ucs_pkg::RESP_SLVERR});
    summarize();
  end
endmodule : usart_control_status_regs_tb_top
